// [common/sep_cfg.svh]
// Purpose: Constants of the two-wire memory access engine
// Assumes: 40 MHz system clock
// Notes: Times in their own unit, cycle counts derived
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH

// Clock and input filter timing
`define SEP_CLK_NS 25
`define SEP_SPIKE_NS 50
`define SEP_SPIKE_CYC ((`SEP_SPIKE_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)

// Self-timed programming cycle, longest time rounds down
`define SEP_TWR_NS 5000000
`define SEP_TWR_CYC (`SEP_TWR_NS / `SEP_CLK_NS)

// Selection byte layout
`define SEP_SEL_FAMILY 4'ha
`define SEP_SEL_FAM_HI 7
`define SEP_SEL_FAM_LO 4
`define SEP_SEL_CS_HI 3
`define SEP_SEL_CS_LO 1
`define SEP_SEL_RW 0

// Array geometry
`define SEP_ADDR_W 13
`define SEP_PAGE_BYTES 32
`define SEP_PAGE_BITS 5
`define SEP_BYTE_BITS 4'h8

`endif

// [common/sep_pkg.sv]
// Purpose: Types of the two-wire memory access engine
// Assumes: Nothing beyond the config header
// Notes: State codes left to the tools
package sep_pkg;

  // Protocol phases of the engine
  typedef enum {
    SEP_IDLE,
    SEP_DEV,
    SEP_ADDR_HI,
    SEP_ADDR_LO,
    SEP_DATA_IN,
    SEP_READ,
    SEP_PROG
  } sep_state_t;

endpackage : sep_pkg

// [rtl/sep_engine.sv]
// Purpose: Target-side two-wire protocol engine for a byte memory
// Assumes: Array sits outside on i_clock; read data follows o_mem_addr within 4 cycles
// Notes: Page data is buffered and written out during the timed programming cycle
`timescale 1ns/1ps
`include "sep_cfg.svh"

module sep_engine
  import sep_pkg::*;
#(
  parameter int ADDR_W = `SEP_ADDR_W,
  parameter int PROG_CYCLES = `SEP_TWR_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Two-wire bus, data is open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Straps and protect pin
  input wire logic [2:0] i_chip_select_straps,
  input wire logic i_write_protect,
  // Memory array port
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_we,
  input wire logic [7:0] i_mem_rdata,
  // Status
  output logic o_busy
);

  localparam int PB = `SEP_PAGE_BYTES;

  initial begin
    if (ADDR_W != 12 && ADDR_W != 13) $error("sep_engine: ADDR_W must be 12 or 13");
    if (PROG_CYCLES < PB + 1) $error("sep_engine: PROG_CYCLES too small");
  end

  // Filtered bus levels and their one-cycle delayed copies
  logic scl, sda;
  logic scl_d, sda_d;

  sep_glitch_filter #(.STABLE(`SEP_SPIKE_CYC)) u_scl_filt (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pin(i_scl),
    .o_level(scl)
  );

  sep_glitch_filter #(.STABLE(`SEP_SPIKE_CYC)) u_sda_filt (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pin(i_sda),
    .o_level(sda)
  );

  // Straps and protect pin pass two flops
  logic [2:0] cs_a, cs_b;
  logic wp_a, wp_b;

  // Bus events seen through the filters
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_seen = scl && scl_d && sda_d && !sda;
  assign stop_seen = scl && scl_d && !sda_d && sda;

  // Engine state
  sep_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic ack_ph, next_ack_ph;
  logic [7:0] shift, next_shift;
  logic drive, next_drive;
  logic rw, next_rw;
  logic [7:0] addr_hi, next_addr_hi;
  logic [ADDR_W-1:0] addr, next_addr;
  logic wrote, next_wrote;
  logic [7:0] page [PB], next_page [PB];
  logic [PB-1:0] pvalid, next_pvalid;
  logic [31:0] prog_cnt, next_prog_cnt;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic next_mem_we;
  logic [`SEP_PAGE_BITS-1:0] pidx;
  logic sel_ok;

  assign pidx = prog_cnt[`SEP_PAGE_BITS-1:0];
  assign sel_ok = (shift[`SEP_SEL_FAM_HI:`SEP_SEL_FAM_LO] == `SEP_SEL_FAMILY) &&
                  (shift[`SEP_SEL_CS_HI:`SEP_SEL_CS_LO] == cs_b);

  // Protocol next-state logic
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ack_ph = ack_ph;
    next_shift = shift;
    next_drive = drive;
    next_rw = rw;
    next_addr_hi = addr_hi;
    next_addr = addr;
    next_wrote = wrote;
    next_page = page;
    next_pvalid = pvalid;
    next_prog_cnt = 32'h0;
    next_mem_we = 1'b0;
    next_mem_wdata = o_mem_wdata;
    next_mem_addr = addr;
    if (state == SEP_PROG) begin
      // Bus is ignored; buffered bytes go out first, then the timer runs out
      next_drive = 1'b0;
      next_prog_cnt = prog_cnt + 32'h1;
      next_mem_addr = {addr[ADDR_W-1:`SEP_PAGE_BITS], pidx};
      if (prog_cnt < 32'(PB) && pvalid[pidx]) begin
        next_mem_we = 1'b1;
        next_mem_wdata = page[pidx];
      end
      if (prog_cnt == 32'(PROG_CYCLES - 1)) begin
        next_state = SEP_IDLE;
      end
    end else if (stop_seen) begin
      next_state = SEP_IDLE;
      next_drive = 1'b0;
      next_wrote = 1'b0;
      if (wrote && !wp_b) begin
        next_state = SEP_PROG;
      end
    end else if (start_seen) begin
      // Repeated start drops any pending page without programming
      next_state = SEP_DEV;
      next_cnt = 4'h0;
      next_ack_ph = 1'b0;
      next_drive = 1'b0;
      next_wrote = 1'b0;
    end else if (state == SEP_READ) begin
      if (scl_rise && ack_ph) begin
        next_rw = !sda; // Controller acknowledge
      end else if (scl_rise) begin
        next_cnt = cnt + 4'h1;
      end else if (scl_fall && ack_ph) begin
        next_ack_ph = 1'b0;
        next_cnt = 4'h0;
        if (rw) begin
          next_shift = i_mem_rdata;
          next_addr = addr + 1'b1;
          next_drive = !i_mem_rdata[7];
        end else begin
          next_state = SEP_IDLE;
          next_drive = 1'b0;
        end
      end else if (scl_fall && cnt == `SEP_BYTE_BITS) begin
        next_drive = 1'b0;
        next_ack_ph = 1'b1;
      end else if (scl_fall) begin
        next_drive = !shift[3'(7 - cnt)];
      end
    end else if (state != SEP_IDLE) begin
      if (scl_rise && !ack_ph && cnt != `SEP_BYTE_BITS) begin
        next_shift = {shift[6:0], sda};
        next_cnt = cnt + 4'h1;
      end else if (scl_fall && !ack_ph && cnt == `SEP_BYTE_BITS) begin
        next_ack_ph = 1'b1;
        next_drive = 1'b1;
        if (state == SEP_DEV) begin
          next_rw = shift[`SEP_SEL_RW];
          if (!sel_ok) begin
            next_state = SEP_IDLE;
            next_drive = 1'b0;
            next_ack_ph = 1'b0;
          end
        end else if (state == SEP_ADDR_HI) begin
          next_addr_hi = shift;
        end else if (state == SEP_ADDR_LO) begin
          next_addr = ADDR_W'({addr_hi, shift});
          next_pvalid = '0;
        end else begin
          next_page[addr[`SEP_PAGE_BITS-1:0]] = shift;
          next_pvalid[addr[`SEP_PAGE_BITS-1:0]] = 1'b1;
          next_addr[`SEP_PAGE_BITS-1:0] = addr[`SEP_PAGE_BITS-1:0] + 1'b1;
          next_wrote = 1'b1;
        end
      end else if (scl_fall && ack_ph) begin
        next_ack_ph = 1'b0;
        next_cnt = 4'h0;
        next_drive = 1'b0;
        case (state)
          SEP_DEV: begin
            if (rw) begin
              next_state = SEP_READ;
              next_shift = i_mem_rdata;
              next_addr = addr + 1'b1;
              next_drive = !i_mem_rdata[7];
            end else begin
              next_state = SEP_ADDR_HI;
            end
          end
          SEP_ADDR_HI: next_state = SEP_ADDR_LO;
          SEP_ADDR_LO: next_state = SEP_DATA_IN;
          default: next_state = state;
        endcase
      end
    end
  end

  // Registers of the engine
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      cs_a <= 3'h0;
      cs_b <= 3'h0;
      wp_a <= 1'b0;
      wp_b <= 1'b0;
      state <= SEP_IDLE;
      cnt <= 4'h0;
      ack_ph <= 1'b0;
      shift <= 8'h00;
      drive <= 1'b0;
      rw <= 1'b0;
      addr_hi <= 8'h00;
      addr <= '0;
      wrote <= 1'b0;
      pvalid <= '0;
      prog_cnt <= 32'h0;
      o_mem_addr <= '0;
      o_mem_wdata <= 8'h00;
      o_mem_we <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      cs_a <= i_chip_select_straps;
      cs_b <= cs_a;
      wp_a <= i_write_protect;
      wp_b <= wp_a;
      state <= next_state;
      cnt <= next_cnt;
      ack_ph <= next_ack_ph;
      shift <= next_shift;
      drive <= next_drive;
      rw <= next_rw;
      addr_hi <= next_addr_hi;
      addr <= next_addr;
      wrote <= next_wrote;
      pvalid <= next_pvalid;
      prog_cnt <= next_prog_cnt;
      o_mem_addr <= next_mem_addr;
      o_mem_wdata <= next_mem_wdata;
      o_mem_we <= next_mem_we;
    end
  end

  // Page buffer carries no reset; pvalid guards its use
  always_ff @(posedge i_clock) begin
    page <= next_page;
  end

  // Open drain: only ever pull low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = drive;
  assign o_busy = (state == SEP_PROG);

endmodule : sep_engine

// [rtl/sep_glitch_filter.sv]
// Purpose: Synchronise a bus pin and drop short spikes
// Assumes: Pin is asynchronous to i_clock
// Notes: Adds STABLE plus two cycles of latency
`timescale 1ns/1ps
`include "sep_cfg.svh"

module sep_glitch_filter #(
  parameter int STABLE = `SEP_SPIKE_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Pin and filtered level
  input wire logic i_pin,
  output logic o_level
);

  logic sync_a;
  logic sync_b;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_level;

  initial begin
    if (STABLE < 1 || STABLE > 200) $error("sep_glitch_filter: STABLE out of range");
  end

  // Level changes only after the new value held STABLE cycles
  always_comb begin
    next_cnt = 8'h00;
    next_level = o_level;
    if (sync_b != o_level) begin
      if (cnt == 8'(STABLE - 1)) begin
        next_level = sync_b;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  // Idle bus is high, so the filter resets high
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      cnt <= 8'h00;
      o_level <= 1'b1;
    end else begin
      sync_a <= i_pin;
      sync_b <= sync_a;
      cnt <= next_cnt;
      o_level <= next_level;
    end
  end

endmodule : sep_glitch_filter

// [sim/sep_bus_ctrl.sv]
// Purpose: Two-wire bus controller model
// Assumes: Data wire resolved by the bench
// Notes: Low phase stretched so the filtered answer settles first
`timescale 1ns/1ps
module sep_bus_ctrl (
  // Resolved data wire
  input wire logic i_sda,
  // Driven clock and released-high data
  output logic o_scl,
  output logic o_sda
);
  logic glitch;
  // Clock idles high and stands still between frames
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
    glitch = 1'h0;
  end
  // One bit: data changes only while clock is low
  // Pin updates are non-blocking so a change that lands on a clock edge is seen after it
  task automatic bit_io(input logic b, output logic r);
    o_scl <= 1'h0;
    #75 o_scl <= glitch;
    #20 o_scl <= 1'h0;
    #55 o_sda <= b;
    #150 o_scl <= 1'h1;
    #100 r = i_sda;
    #100;
  endtask : bit_io
  // Start, also repeated start
  task automatic start;
    o_scl <= 1'h0;
    #150 o_sda <= 1'h1;
    #150 o_scl <= 1'h1;
    #150 o_sda <= 1'h0;
    #150;
  endtask : start
  task automatic stop;
    o_scl <= 1'h0;
    #150 o_sda <= 1'h0;
    #150 o_scl <= 1'h1;
    #150 o_sda <= 1'h1;
    #150;
  endtask : stop
  // Byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic rd, input logic nak, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd | d[i], r);
      q[i] = r;
    end
    bit_io(rd ? nak : 1'h1, r);
    ack = !r;
  endtask : xfer
endmodule : sep_bus_ctrl

// [sim/sep_engine_properties.sv]
// Purpose: Concurrent checks on the memory access engine ports
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Cycle counters stand in for long repetitions
`timescale 1ns/1ps
module sep_engine_properties #(
  parameter int ADDR_W = 13,
  parameter int PROG_CYCLES = 100
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Bus and pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [2:0] i_chip_select_straps,
  input wire logic i_write_protect,
  // Array port and status
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_mem_we,
  input wire logic [7:0] i_mem_rdata,
  input wire logic o_busy
);
  int busy_cnt;
  int we_cnt;
  int next_busy_cnt;
  int next_we_cnt;
  // Length of the busy spell and bytes written in it
  always_comb begin
    next_busy_cnt = (i_rstn && o_busy) ? busy_cnt + 1 : 0;
    next_we_cnt = (i_rstn && o_busy) ? we_cnt + int'(o_mem_we) : 0;
  end
  always_ff @(posedge i_clock) begin
    busy_cnt <= next_busy_cnt;
    we_cnt <= next_we_cnt;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  a_open_drain: assert property (o_sda_out == 1'h0) else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("data changed in clock high");
  a_busy_silent: assert property (o_busy |-> !o_sda_oe) else $error("answer while programming");
  a_we_in_prog: assert property (o_mem_we |-> o_busy) else $error("write outside programming");
  a_busy_length: assert property ($fell(o_busy) |->
    busy_cnt >= PROG_CYCLES - 2 && busy_cnt <= PROG_CYCLES + 2) else $error("programming length wrong");
  a_page_limit: assert property (we_cnt <= 32) else $error("more than a page written");
  a_page_order: assert property (o_mem_we ##1 o_mem_we |-> $stable(o_mem_addr[ADDR_W-1:5])
    && o_mem_addr[4:0] == $past(o_mem_addr[4:0]) + 5'h1) else $error("page write order wrong");
  a_wp_blocks: assert property (i_write_protect [*8] |=> !$rose(o_busy))
    else $error("protected write programmed");
  c_prog_done: cover property ($fell(o_busy));
  c_page_end: cover property (o_mem_we && o_mem_addr[4:0] == 5'h1f);
  c_ack: cover property ($rose(o_sda_oe));
endmodule : sep_engine_properties

bind sep_engine sep_engine_properties #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_props (.i_clock, .i_rstn,
  .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_chip_select_straps, .i_write_protect, .o_mem_addr, .o_mem_wdata,
  .o_mem_we, .i_mem_rdata, .o_busy);

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the memory access engine
// Assumes: Array model answers one cycle after address
// Notes: Reference array and counter mirror every transfer
`timescale 1ns/1ps
module tb_top;
  logic i_clock, i_rstn, scl, m_sda, sda_oe, sda_out, we, busy, wp, ack;
  logic [2:0] straps;
  logic [12:0] addr;
  logic [7:0] wdata, rdata, q;
  logic [7:0] mem [0:8191];
  logic [7:0] ref_mem [0:8191];
  int failures, num_checks, seed, ctr;
  wire logic sda_w = sda_oe ? (sda_out & m_sda) : m_sda;
  sep_engine #(.ADDR_W(13), .PROG_CYCLES(100)) dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_scl(scl),
    .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_chip_select_straps(straps),
    .i_write_protect(wp), .o_mem_addr(addr), .o_mem_wdata(wdata), .o_mem_we(we), .i_mem_rdata(rdata),
    .o_busy(busy));
  sep_bus_ctrl m (.i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
  // Array model
  always @(posedge i_clock) begin
    rdata <= mem[addr];
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  initial begin
    i_clock = 1'h0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic chk_ack(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t ack %b", $time, got);
    end
  endtask : chk_ack
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_busy(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t busy %b", $time, got);
    end
  endtask : chk_busy
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // Pins change at the clock edge, then settle through the synchronisers
  task automatic pins(input logic [2:0] cs, input logic p);
    @(posedge i_clock);
    straps <= cs;
    wp <= p;
    repeat (4) @(posedge i_clock);
  endtask : pins
  // Write of n bytes; n of zero leaves a dummy write open
  task automatic wr(input logic [12:0] a, input int n);
    logic [7:0] d;
    m.start();
    m.xfer({4'ha, straps, 1'h0}, 1'h0, 1'h0, q, ack);
    chk_ack(ack, 1'h1);
    m.xfer({3'h5, a[12:8]}, 1'h0, 1'h0, q, ack);
    chk_ack(ack, 1'h1);
    m.xfer(a[7:0], 1'h0, 1'h0, q, ack);
    chk_ack(ack, 1'h1);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      m.xfer(d, 1'h0, 1'h0, q, ack);
      chk_ack(ack, 1'h1);
      if (!wp) begin
        ref_mem[a] = d;
      end
      a[4:0] = a[4:0] + 5'h1;
    end
    ctr = a;
    if (n > 0) begin
      m.stop();
    end
  endtask : wr
  // Poll until programming ends; first try nacked while busy
  task automatic poll(input logic prog);
    for (int k = 0; k < 5 && !(k > 0 && ack); k++) begin
      m.start();
      if (k == 0) begin
        chk_busy(busy, prog);
      end
      m.xfer({4'ha, straps, 1'h0}, 1'h0, 1'h0, q, ack);
      if (k == 0) begin
        chk_ack(ack, !prog);
      end
    end
    chk_ack(ack, 1'h1);
    if (!ack) begin
      give_verdict();
    end
    m.stop();
  endtask : poll
  // Read n bytes from the current counter
  task automatic rd(input int n);
    m.start();
    m.xfer({4'ha, straps, 1'h1}, 1'h0, 1'h0, q, ack);
    chk_ack(ack, 1'h1);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hff, 1'h1, i == n - 1, q, ack);
      chk_byte(q, ref_mem[ctr]);
      ctr = (ctr + 1) % 8192;
    end
    m.stop();
  endtask : rd
  initial begin
    seed = 7;
    i_rstn = 1'h0;
    wp = 1'h0;
    straps = 3'h5;
    ctr = 0;
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'($random(seed));
      ref_mem[i] = mem[i];
    end
    repeat (4) @(posedge i_clock);
    i_rstn <= 1'h1;
    repeat (8) @(posedge i_clock);
    rd(2);
    wr(13'h0a3c, 34);
    poll(1'h1);
    rd(3);
    wr(13'h0a20, 0);
    rd(32);
    wr(13'h1ffe, 0);
    rd(3);
    pins(3'h2, 1'h0);
    m.glitch = 1'h1;
    wr(13'h0100, 1);
    m.glitch = 1'h0;
    poll(1'h1);
    pins(3'h2, 1'h1);
    wr(13'h0101, 2);
    poll(1'h0);
    pins(3'h2, 1'h0);
    wr(13'h0100, 0);
    rd(3);
    for (int j = 0; j < 2; j++) begin
      m.start();
      m.xfer(j ? {4'h5, straps, 1'h1} : {4'ha, ~straps, 1'h1}, 1'h0, 1'h0, q, ack);
      chk_ack(ack, 1'h0);
      m.stop();
    end
    give_verdict();
  end
endmodule : tb_top
